//--- mnef_top.sv
// protected data ram and ecc-checked code flash fetch path with software flash access
`timescale 1ns/1ps
`include "mnef_map.svh"

module mnef_top
   import mnef_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // data ram port
   input  wire mnef_dreq_t  dreq,
   input  wire logic [12:0] dinject,
   output logic [7:0]       drdata_q,
   output logic             drvalid_q,
   output logic             dcorr_q,
   // program fetch port
   input  wire logic        fetch_en,
   input  wire logic [14:0] fetch_addr,
   output logic             fetch_ready,
   output logic [7:0]       fetch_data_q,
   output logic             fetch_valid_q,
   output logic             fetch_corr_q,
   // software flash controller port
   input  wire mnef_creq_t  creq,
   output logic             cready,
   output logic [15:0]      crdata_q,
   output logic [7:0]       crbyte_q,
   output logic             cdone_q,
   output logic             crefused_q,
   // flash array
   output mnef_areq_t       areq,
   input  wire logic [15:0] ardata,
   // error status
   input  wire logic        derr_clear,
   output logic             derr_flag_q
);

   localparam int WS = `MNEF_FETCH_WS;

   // sram word: {parity, check[3:0], data[7:0]}
   function automatic logic [12:0] enc8(input logic [7:0] d);
      logic [3:0]  s;
      logic [31:0] cols;
      s    = 4'h0;
      cols = `MNEF_H8_COLS;
      for (int i = 0; i < 8; i++) begin
         if (d[i]) begin
            s = s ^ cols[i*4 +: 4];
         end
      end
      enc8 = {^{s, d}, s, d};
   endfunction

   function automatic mnef_ecc_t dec8(input logic [12:0] w);
      mnef_ecc_t   r;
      logic [3:0]  s;
      logic [31:0] cols;
      logic        p;
      cols   = `MNEF_H8_COLS;
      s      = w[`MNEF_SR_CHK_LSB +: 4];
      p      = ^w;
      r.data = w[7:0];
      r.corr = 1'b0;
      r.derr = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (w[i]) begin
            s = s ^ cols[i*4 +: 4];
         end
      end
      if (p) begin
         r.corr = 1'b1;
         for (int i = 0; i < 8; i++) begin
            if (s == cols[i*4 +: 4]) begin
               r.data[i] = ~w[i];
            end
         end
      end else if (s != 4'h0) begin
         r.derr = 1'b1;
      end
      dec8 = r;
   endfunction

   // nibble check code: {parity, check[2:0]}
   function automatic logic [3:0] enc4(input logic [3:0] d);
      logic [2:0]  s;
      logic [11:0] cols;
      s    = 3'h0;
      cols = `MNEF_H4_COLS;
      for (int i = 0; i < 4; i++) begin
         if (d[i]) begin
            s = s ^ cols[i*3 +: 3];
         end
      end
      enc4 = {^{s, d}, s};
   endfunction

   // returns {derr, corr, nibble}
   function automatic logic [5:0] dec4(input logic [3:0] d, input logic [3:0] c);
      logic [2:0]  s;
      logic [11:0] cols;
      logic [3:0]  o;
      logic        corr;
      logic        derr;
      cols = `MNEF_H4_COLS;
      s    = c[2:0];
      o    = d;
      corr = 1'b0;
      derr = 1'b0;
      for (int i = 0; i < 4; i++) begin
         if (d[i]) begin
            s = s ^ cols[i*3 +: 3];
         end
      end
      if (^{c, d}) begin
         corr = 1'b1;
         for (int i = 0; i < 4; i++) begin
            if (s == cols[i*3 +: 3]) begin
               o[i] = ~d[i];
            end
         end
      end else if (s != 3'h0) begin
         derr = 1'b1;
      end
      dec4 = {derr, corr, o};
   endfunction

   // ---------------- data ram ----------------
   // ecc word storage
   logic [12:0] sram [`MNEF_SRAM_WORDS];
   logic [10:0] sidx;
   logic        shit;
   mnef_ecc_t   sdec;
   logic [7:0]  drdata_d;
   logic        drvalid_d;
   logic        dcorr_d;
   logic        dderr;

   always_comb begin
      sidx = dreq.addr[10:0];
      shit = 1'b0;
      if (!dreq.ext) begin
         sidx = {3'h0, dreq.addr[7:0]};
         shit = (dreq.addr < 16'(`MNEF_INTERNAL_DATA_RAM_BYTES));
      end else begin
         shit = (dreq.addr >= `MNEF_EXTENDED_DATA_RAM_BASE) && (dreq.addr <= `MNEF_EXTENDED_DATA_RAM_LAST);
      end
      sdec      = dec8(sram[sidx]);
      drvalid_d = dreq.valid && !dreq.we;
      drdata_d  = (drvalid_d && shit) ? sdec.data : `MNEF_RD_ZERO;
      dcorr_d   = drvalid_d && shit && sdec.corr;
      dderr     = drvalid_d && shit && sdec.derr;
   end

   // storage has no reset; unwritten words read as garbage and may flag errors
   always_ff @(posedge clk) begin
      if (dreq.valid && dreq.we && shit) begin
         sram[sidx] <= enc8(dreq.wdata) ^ dinject;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         drdata_q  <= `MNEF_RD_ZERO;
         drvalid_q <= 1'b0;
         dcorr_q   <= 1'b0;
      end else begin
         drdata_q  <= drdata_d;
         drvalid_q <= drvalid_d;
         dcorr_q   <= dcorr_d;
      end
   end

   // ---------------- program fetch ----------------
   logic [3:0]  ws_q;
   logic [3:0]  ws_d;
   logic        ftake;
   logic [5:0]  nlo;
   logic [5:0]  nhi;
   logic [7:0]  fetch_data_d;
   logic        fetch_valid_d;
   logic        fetch_corr_d;
   logic        fderr;

   always_comb begin
      // zero wait states at this clock
      fetch_ready = (ws_q == 4'h0);
      ftake       = fetch_en && fetch_ready;
      ws_d        = (ws_q != 4'h0) ? ws_q - 4'h1 : (ftake ? 4'(WS) : 4'h0);
      // low byte code, high byte check
      nlo = dec4(ardata[3:0], ardata[`MNEF_FL_CHK_LSB +: 4]);
      nhi = dec4(ardata[7:4], ardata[`MNEF_FL_CHK_LSB + 4 +: 4]);
      fetch_valid_d = ftake;
      fetch_data_d  = ftake ? {nhi[3:0], nlo[3:0]} : fetch_data_q;
      fetch_corr_d  = ftake && (nhi[4] || nlo[4]);
      fderr         = ftake && (nhi[5] || nlo[5]);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ws_q          <= 4'h0;
         fetch_data_q  <= 8'h00;
         fetch_valid_q <= 1'b0;
         fetch_corr_q  <= 1'b0;
      end else begin
         ws_q          <= ws_d;
         fetch_data_q  <= fetch_data_d;
         fetch_valid_q <= fetch_valid_d;
         fetch_corr_q  <= fetch_corr_d;
      end
   end

   // ---------------- software flash controller ----------------
   mnef_state_t  st_q;
   mnef_state_t  st_d;
   mnef_blk_t    eblk_q;
   mnef_blk_t    eblk_d;
   logic [14:0]  eaddr_q;
   logic [14:0]  eaddr_d;
   logic [15:0]  crdata_d;
   logic [7:0]   crbyte_d;
   logic         cdone_d;
   logic         crefused_d;
   logic         ctake;
   logic         ckey;
   logic         cderr;
   logic [5:0]   clo;
   logic [5:0]   chi;

   always_comb begin
      st_d       = st_q;
      eblk_d     = eblk_q;
      eaddr_d    = eaddr_q;
      crdata_d   = crdata_q;
      crbyte_d   = crbyte_q;
      cdone_d    = 1'b0;
      crefused_d = 1'b0;
      cderr      = 1'b0;
      // fetch owns the array; software waits
      cready     = (st_q == MNEF_ST_IDLE) && !fetch_en;
      ctake      = creq.valid && cready;
      ckey       = (creq.blk == MNEF_BLK_MAIN) && (creq.addr >= `MNEF_KEY_BASE);
      areq.en    = fetch_en;
      areq.we    = 1'b0;
      areq.blk   = MNEF_BLK_MAIN;
      areq.addr  = fetch_addr;
      areq.wdata = `MNEF_ERASED;
      clo        = dec4(ardata[3:0], ardata[`MNEF_FL_CHK_LSB +: 4]);
      chi        = dec4(ardata[7:4], ardata[`MNEF_FL_CHK_LSB + 4 +: 4]);
      case (st_q)
         MNEF_ST_IDLE: begin
            if (ctake) begin
               areq.en   = 1'b1;
               areq.blk  = creq.blk;
               areq.addr = creq.addr;
               case (creq.op)
                  MNEF_OP_READ: begin
                     cdone_d = 1'b1;
                     if (ckey || creq.blk == MNEF_BLK_NONE) begin
                        crdata_d   = 16'h0000;
                        crbyte_d   = `MNEF_RD_ZERO;
                        crefused_d = 1'b1;
                     end else begin
                        crdata_d = ardata;
                        crbyte_d = {chi[3:0], clo[3:0]};
                        cderr    = chi[5] || clo[5];
                     end
                  end
                  MNEF_OP_WRITE: begin
                     cdone_d = 1'b1;
                     // first info block one-time: only erased words take data
                     if (creq.blk == MNEF_BLK_NONE ||
                         (creq.blk == MNEF_BLK_INFO0 && ardata != `MNEF_ERASED)) begin
                        crefused_d = 1'b1;
                     end else begin
                        areq.we    = 1'b1;
                        areq.wdata = {enc4(creq.wdata[7:4]), enc4(creq.wdata[3:0]), creq.wdata};
                     end
                  end
                  MNEF_OP_ERASE: begin
                     if (creq.blk == MNEF_BLK_INFO0 || creq.blk == MNEF_BLK_NONE) begin
                        cdone_d    = 1'b1;
                        crefused_d = 1'b1;
                     end else begin
                        // whole page from its first word
                        st_d    = MNEF_ST_ERASE;
                        eblk_d  = creq.blk;
                        eaddr_d = {creq.addr[14:`MNEF_PAGE_AW], 9'h000};
                     end
                  end
                  default: begin
                     cdone_d    = 1'b1;
                     crefused_d = 1'b1;
                  end
               endcase
            end
         end
         MNEF_ST_ERASE: begin
            // erase pauses while a fetch holds the array
            if (!fetch_en) begin
               areq.en    = 1'b1;
               areq.we    = 1'b1;
               areq.blk   = eblk_q;
               areq.addr  = eaddr_q;
               areq.wdata = `MNEF_ERASED;
               eaddr_d    = eaddr_q + 15'h0001;
               if (eaddr_q[`MNEF_PAGE_AW-1:0] == 9'h1ff) begin
                  st_d    = MNEF_ST_IDLE;
                  cdone_d = 1'b1;
               end
            end
         end
         default: begin
            st_d = MNEF_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_q       <= MNEF_ST_IDLE;
         eblk_q     <= MNEF_BLK_MAIN;
         eaddr_q    <= 15'h0000;
         crdata_q   <= 16'h0000;
         crbyte_q   <= 8'h00;
         cdone_q    <= 1'b0;
         crefused_q <= 1'b0;
      end else begin
         st_q       <= st_d;
         eblk_q     <= eblk_d;
         eaddr_q    <= eaddr_d;
         crdata_q   <= crdata_d;
         crbyte_q   <= crbyte_d;
         cdone_q    <= cdone_d;
         crefused_q <= crefused_d;
      end
   end

   // ---------------- double error flag ----------------
   logic derr_flag_d;

   always_comb begin
      derr_flag_d = (derr_flag_q && !derr_clear) || dderr || fderr || cderr;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         derr_flag_q <= 1'b0;
      end else begin
         derr_flag_q <= derr_flag_d;
      end
   end

endmodule

//--- mnef_map.svh
// memory map, field positions, reset values and timing counts of the protected memory block
`ifndef MNEF_MAP_SVH
`define MNEF_MAP_SVH

`define MNEF_INTERNAL_DATA_RAM_BYTES  256
`define MNEF_EXTENDED_DATA_RAM_BASE   16'h0100
`define MNEF_EXTENDED_DATA_RAM_LAST   16'h07ff
`define MNEF_EXTENDED_DATA_RAM_BYTES  1792
`define MNEF_SRAM_WORDS               2048
`define MNEF_SRAM_AW                  11
`define MNEF_SRAM_W                   13
`define MNEF_SR_CHK_LSB               8
`define MNEF_SR_PAR_BIT               12
`define MNEF_FL_WORDS                 32768
`define MNEF_FL_AW                    15
`define MNEF_PAGE_WORDS               512
`define MNEF_PAGE_AW                  9
`define MNEF_INFORMATION_BLOCK_WORDS  512
`define MNEF_FL_CHK_LSB               8
`define MNEF_KEY_BYTES                8
`define MNEF_KEY_BASE                 15'h7ff8
`define MNEF_ERASED                   16'hffff
`define MNEF_RD_ZERO                  8'h00
`define MNEF_H8_COLS                  32'hb7ca9653
`define MNEF_H4_COLS                  12'hfab
`define MNEF_CLK_HZ                   10000000
`define MNEF_ZWS_MAX_HZ               16000000
`define MNEF_CORE_MAX_HZ              25000000
`define MNEF_FETCH_WS                 ((`MNEF_CLK_HZ + `MNEF_ZWS_MAX_HZ - 1) / `MNEF_ZWS_MAX_HZ - 1)

`endif

//--- mnef_pkg.sv
// types shared by the protected memory block and its users
package mnef_pkg;

   typedef enum logic [1:0] {
      MNEF_OP_READ  = 2'b00,
      MNEF_OP_WRITE = 2'b01,
      MNEF_OP_ERASE = 2'b10,
      MNEF_OP_NONE  = 2'b11
   } mnef_op_t;

   typedef enum logic [1:0] {
      MNEF_BLK_MAIN = 2'b00,
      MNEF_BLK_INFO0 = 2'b01,
      MNEF_BLK_INFO1 = 2'b10,
      MNEF_BLK_NONE = 2'b11
   } mnef_blk_t;

   typedef enum logic [1:0] {
      MNEF_ST_IDLE  = 2'b00,
      MNEF_ST_ERASE = 2'b01
   } mnef_state_t;

   // processor data access, internal or extended space
   typedef struct packed {
      logic        valid;
      logic        we;
      logic        ext;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } mnef_dreq_t;

   // software flash controller command
   typedef struct packed {
      logic        valid;
      mnef_op_t    op;
      mnef_blk_t   blk;
      logic [14:0] addr;
      logic [7:0]  wdata;
   } mnef_creq_t;

   // flash array port
   typedef struct packed {
      logic        en;
      logic        we;
      mnef_blk_t   blk;
      logic [14:0] addr;
      logic [15:0] wdata;
   } mnef_areq_t;

   typedef struct packed {
      logic [7:0] data;
      logic       corr;
      logic       derr;
   } mnef_ecc_t;

endpackage

//--- mnef_top_assertions.sv
// concurrent checks on the ports of the protected memory block
`timescale 1ns/1ps
module mnef_top_checker
   import mnef_pkg::*;
(
   // clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // data ram port
   input wire mnef_dreq_t  dreq,
   input wire logic [7:0]  drdata_q,
   input wire logic        drvalid_q,
   input wire logic        dcorr_q,
   // fetch port
   input wire logic        fetch_en,
   input wire logic [14:0] fetch_addr,
   input wire logic        fetch_ready,
   input wire logic        fetch_valid_q,
   input wire logic        fetch_corr_q,
   // controller and array
   input wire mnef_creq_t  creq,
   input wire logic        cready,
   input wire logic        cdone_q,
   input wire logic        crefused_q,
   input wire mnef_areq_t  areq,
   // error status
   input wire logic        derr_clear,
   input wire logic        derr_flag_q
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   logic rd_c;
   logic out_c;
   logic key_c;
   assign rd_c  = dreq.valid && !dreq.we;
   assign out_c = dreq.ext ? (dreq.addr < 16'h0100 || dreq.addr > 16'h07ff) : (dreq.addr > 16'h00ff);
   assign key_c = creq.valid && cready && creq.op == MNEF_OP_READ && creq.blk == MNEF_BLK_MAIN
                  && creq.addr >= 15'h7ff8;

   a_fetch_ready: assert property (fetch_ready)
      else $error("fetch wait state seen");
   a_fetch_answer: assert property (fetch_en |=> fetch_valid_q)
      else $error("fetch not answered next cycle");
   a_fetch_quiet: assert property (!fetch_en |=> !fetch_valid_q && !fetch_corr_q)
      else $error("fetch result without fetch");
   a_fetch_array: assert property (fetch_en |-> areq.en && !areq.we && areq.addr == fetch_addr)
      else $error("fetch address not on array");
   a_read_answer: assert property (rd_c |=> drvalid_q)
      else $error("data read not answered");
   a_read_quiet: assert property (!rd_c |=> !drvalid_q && !dcorr_q)
      else $error("data result without read");
   a_out_window: assert property (rd_c && out_c |=> drdata_q == 8'h00 && !dcorr_q)
      else $error("out of window read not zero");
   a_flag_sticky: assert property (derr_flag_q && !derr_clear |=> derr_flag_q)
      else $error("error flag lost");
   a_flag_clear: assert property (derr_clear && !dreq.valid && !fetch_en && !creq.valid |=> !derr_flag_q)
      else $error("error flag not cleared");
   a_ctrl_block: assert property (fetch_en |-> !cready)
      else $error("controller not blocked by fetch");
   a_key_refused: assert property (key_c |=> cdone_q && crefused_q)
      else $error("key read not refused");
   a_otp_erase: assert property (creq.valid && cready && creq.op == MNEF_OP_ERASE
                                 && creq.blk == MNEF_BLK_INFO0 |=> crefused_q)
      else $error("first info block erased");
endmodule

//--- mnef_flash_model.sv
// behavioural flash array with asynchronous read and clocked word write
`timescale 1ns/1ps
module mnef_flash_model
   import mnef_pkg::*;
(
   // clock
   input wire logic        clk,
   // array port
   input wire mnef_areq_t  areq,
   output logic [15:0]     ardata
);
   // main array and both info blocks, indexed by block then word
   logic [15:0] mem [131072];
   logic [15:0] last_q;

   initial begin
      last_q = 16'h0000;
      for (int i = 0; i < 131072; i++) begin
         mem[i] = 16'hffff;
      end
   end

   // sixteen-bit words in four blocks of 32768, one per block code
   // a deselected array shows no stale word, so the design cannot lean on it
   assign ardata = areq.en ? mem[{areq.blk, areq.addr}] : ~last_q;

   // erase lands as word writes of all ones
   always @(posedge clk) begin
      last_q <= ardata;
      if (areq.en && areq.we) begin
         mem[{areq.blk, areq.addr}] <= areq.wdata;
      end
   end
endmodule

//--- mnef_top_tb.sv
// self-checking bench for the protected memory block
`timescale 1ns/1ps
`define MNEF_CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_errors++; \
   $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end
module mnef_top_tb
   import mnef_pkg::*;
;
   logic        clk;
   logic        rst;
   mnef_dreq_t  dreq;
   logic [12:0] dinject;
   logic [7:0]  drdata_q;
   logic        drvalid_q;
   logic        dcorr_q;
   logic        fetch_en;
   logic [14:0] fetch_addr;
   logic        fetch_ready;
   logic [7:0]  fetch_data_q;
   logic        fetch_valid_q;
   logic        fetch_corr_q;
   mnef_creq_t  creq;
   logic        cready;
   logic [15:0] crdata_q;
   logic [7:0]  crbyte_q;
   logic        cdone_q;
   logic        crefused_q;
   mnef_areq_t  areq;
   logic [15:0] ardata;
   logic        derr_clear;
   logic        derr_flag_q;
   int          n_errors;
   int          n_checks;

   mnef_top i_mnef_top (.clk, .rst, .dreq, .dinject, .drdata_q, .drvalid_q, .dcorr_q, .fetch_en,
      .fetch_addr, .fetch_ready, .fetch_data_q, .fetch_valid_q, .fetch_corr_q, .creq, .cready,
      .crdata_q, .crbyte_q, .cdone_q, .crefused_q, .areq, .ardata, .derr_clear, .derr_flag_q);
   mnef_flash_model i_mnef_flash_model (.clk, .areq, .ardata);

   initial clk = 1'b0;
   always #50 clk = ~clk;

   function automatic logic [3:0] enc4(logic [3:0] n);
      logic [2:0] c;
      c = (n[0] ? 3'h3 : 3'h0) ^ (n[1] ? 3'h5 : 3'h0) ^ (n[2] ? 3'h6 : 3'h0) ^ (n[3] ? 3'h7 : 3'h0);
      return {^{n, c}, c};
   endfunction

   function automatic logic [15:0] fword(logic [7:0] b);
      return {enc4(b[7:4]), enc4(b[3:0]), b};
   endfunction

   task automatic dacc(logic we, logic ext, logic [15:0] a, logic [7:0] d, logic [12:0] inj);
      @(posedge clk);
      dreq <= '{valid: 1'b1, we: we, ext: ext, addr: a, wdata: d};
      dinject <= inj;
      @(posedge clk);
      dreq.valid <= 1'b0;
      dinject <= 13'h0000;
      #1;
   endtask

   task automatic fetch(logic [14:0] a);
      @(posedge clk);
      fetch_en <= 1'b1;
      fetch_addr <= a;
      @(posedge clk);
      fetch_en <= 1'b0;
      #1;
   endtask

   task automatic ctrl(mnef_op_t op, mnef_blk_t b, logic [14:0] a, logic [7:0] d, output int n);
      @(posedge clk);
      creq <= '{valid: 1'b1, op: op, blk: b, addr: a, wdata: d};
      @(posedge clk);
      creq.valid <= 1'b0;
      #1;
      n = 0;
      while (cdone_q !== 1'b1 && n < 600) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask

   task automatic clear_flag();
      @(posedge clk);
      derr_clear <= 1'b1;
      @(posedge clk);
      derr_clear <= 1'b0;
      #1;
      `MNEF_CHK(derr_flag_q, 1'b0)
   endtask

   task automatic test_dram();
      logic [12:0] inj [3] = '{13'h0004, 13'h0100, 13'h1000};
      dacc(1'b1, 1'b1, 16'h0100, 8'h3c, 13'h0000);
      dacc(1'b1, 1'b1, 16'h07ff, 8'hc3, 13'h0000);
      dacc(1'b1, 1'b0, 16'h00ff, 8'h96, 13'h0000);
      dacc(1'b0, 1'b1, 16'h0100, 8'h00, 13'h0000);
      `MNEF_CHK({drvalid_q, drdata_q}, 9'h13c)
      dacc(1'b0, 1'b1, 16'h07ff, 8'h00, 13'h0000);
      `MNEF_CHK(drdata_q, 8'hc3)
      dacc(1'b0, 1'b0, 16'h00ff, 8'h00, 13'h0000);
      `MNEF_CHK(drdata_q, 8'h96)
      // the internal byte at 0xff must not leak into the extended space
      dacc(1'b0, 1'b1, 16'h00ff, 8'h00, 13'h0000);
      `MNEF_CHK({drvalid_q, drdata_q}, 9'h100)
      dacc(1'b0, 1'b1, 16'h0800, 8'h00, 13'h0000);
      `MNEF_CHK({drvalid_q, drdata_q}, 9'h100)
      for (int i = 0; i < 3; i++) begin
         dacc(1'b1, 1'b1, 16'h0200 + 16'(i), 8'h5a, inj[i]);
         dacc(1'b0, 1'b1, 16'h0200 + 16'(i), 8'h00, 13'h0000);
         `MNEF_CHK({dcorr_q, drdata_q, derr_flag_q}, 10'h2b4)
      end
      dacc(1'b1, 1'b1, 16'h0203, 8'h18, 13'h0003);
      dacc(1'b0, 1'b1, 16'h0203, 8'h00, 13'h0000);
      `MNEF_CHK(derr_flag_q, 1'b1)
      clear_flag();
      $display("test_dram done");
   endtask

   task automatic test_fetch();
      logic [15:0] flip [5] = '{16'h0000, 16'h0001, 16'h0011, 16'h1000, 16'h0080};
      for (int i = 0; i < 5; i++) begin
         i_mnef_flash_model.mem[{MNEF_BLK_MAIN, 15'h0010}] = fword(8'h5a) ^ flip[i];
         fetch(15'h0010);
         `MNEF_CHK({fetch_valid_q, fetch_corr_q, fetch_data_q}, {1'b1, i != 0, 8'h5a})
      end
      `MNEF_CHK({fetch_ready, derr_flag_q}, 2'b10)
      i_mnef_flash_model.mem[{MNEF_BLK_MAIN, 15'h0010}] = fword(8'h5a) ^ 16'h0003;
      fetch(15'h0010);
      `MNEF_CHK(derr_flag_q, 1'b1)
      clear_flag();
      $display("test_fetch done");
   endtask

   task automatic test_ctrl();
      int n;
      ctrl(MNEF_OP_WRITE, MNEF_BLK_MAIN, 15'h0100, 8'ha5, n);
      `MNEF_CHK({cdone_q, crefused_q, i_mnef_flash_model.mem[{MNEF_BLK_MAIN, 15'h0100}]},
                {2'b10, fword(8'ha5)})
      ctrl(MNEF_OP_READ, MNEF_BLK_MAIN, 15'h0100, 8'h00, n);
      `MNEF_CHK({crefused_q, crdata_q, crbyte_q}, {1'b0, fword(8'ha5), 8'ha5})
      i_mnef_flash_model.mem[{MNEF_BLK_MAIN, 15'h7ff8}] = fword(8'h77);
      ctrl(MNEF_OP_READ, MNEF_BLK_MAIN, 15'h7ff8, 8'h00, n);
      `MNEF_CHK({cdone_q, crefused_q}, 2'b11)
      ctrl(MNEF_OP_READ, MNEF_BLK_MAIN, 15'h7ff7, 8'h00, n);
      `MNEF_CHK({cdone_q, crefused_q}, 2'b10)
      fetch(15'h7ff8);
      `MNEF_CHK(fetch_data_q, 8'h77)
      ctrl(MNEF_OP_NONE, MNEF_BLK_MAIN, 15'h0000, 8'h00, n);
      `MNEF_CHK({cdone_q, crefused_q}, 2'b11)
      ctrl(MNEF_OP_READ, MNEF_BLK_NONE, 15'h0000, 8'h00, n);
      `MNEF_CHK({cdone_q, crefused_q}, 2'b11)
      ctrl(MNEF_OP_WRITE, MNEF_BLK_INFO0, 15'h0005, 8'h12, n);
      `MNEF_CHK({crefused_q, i_mnef_flash_model.mem[{MNEF_BLK_INFO0, 15'h0005}]}, {1'b0, fword(8'h12)})
      ctrl(MNEF_OP_WRITE, MNEF_BLK_INFO0, 15'h0005, 8'h34, n);
      `MNEF_CHK({crefused_q, i_mnef_flash_model.mem[{MNEF_BLK_INFO0, 15'h0005}]}, {1'b1, fword(8'h12)})
      ctrl(MNEF_OP_ERASE, MNEF_BLK_INFO0, 15'h0000, 8'h00, n);
      `MNEF_CHK({crefused_q, i_mnef_flash_model.mem[{MNEF_BLK_INFO0, 15'h0005}]}, {1'b1, fword(8'h12)})
      // software reads are corrected as well, and a double error there raises the flag
      i_mnef_flash_model.mem[{MNEF_BLK_MAIN, 15'h0101}] = fword(8'h3c) ^ 16'h0004;
      ctrl(MNEF_OP_READ, MNEF_BLK_MAIN, 15'h0101, 8'h00, n);
      `MNEF_CHK({crdata_q, crbyte_q, derr_flag_q}, {fword(8'h3c) ^ 16'h0004, 8'h3c, 1'b0})
      i_mnef_flash_model.mem[{MNEF_BLK_MAIN, 15'h0101}] = fword(8'h3c) ^ 16'h0060;
      ctrl(MNEF_OP_READ, MNEF_BLK_MAIN, 15'h0101, 8'h00, n);
      `MNEF_CHK(derr_flag_q, 1'b1)
      clear_flag();
      $display("test_ctrl done");
   endtask

   task automatic test_erase();
      int n;
      ctrl(MNEF_OP_WRITE, MNEF_BLK_INFO1, 15'h0003, 8'h21, n);
      ctrl(MNEF_OP_WRITE, MNEF_BLK_INFO1, 15'h0003, 8'h00, n);
      `MNEF_CHK(crefused_q, 1'b0)
      // done shows 512 cycles after the return of the take, one per erased word
      ctrl(MNEF_OP_ERASE, MNEF_BLK_INFO1, 15'h0000, 8'h00, n);
      `MNEF_CHK({n, crefused_q, i_mnef_flash_model.mem[{MNEF_BLK_INFO1, 15'h0003}]}, {32'd512, 1'b0, 16'hffff})
      i_mnef_flash_model.mem[{MNEF_BLK_MAIN, 15'h01ff}] = 16'h0000;
      i_mnef_flash_model.mem[{MNEF_BLK_MAIN, 15'h03ff}] = 16'h0000;
      i_mnef_flash_model.mem[{MNEF_BLK_MAIN, 15'h0400}] = 16'h0000;
      ctrl(MNEF_OP_ERASE, MNEF_BLK_MAIN, 15'h0234, 8'h00, n);
      `MNEF_CHK(n, 512)
      `MNEF_CHK({i_mnef_flash_model.mem[{MNEF_BLK_MAIN, 15'h01ff}], i_mnef_flash_model.mem[{MNEF_BLK_MAIN, 15'h03ff}],
                 i_mnef_flash_model.mem[{MNEF_BLK_MAIN, 15'h0400}]}, 48'h0000_ffff_0000)
      $display("test_erase done");
   endtask

   task automatic test_reset();
      i_mnef_flash_model.mem[{MNEF_BLK_MAIN, 15'h0020}] = fword(8'h5a) ^ 16'h0300;
      fetch(15'h0020);
      `MNEF_CHK({fetch_valid_q, derr_flag_q}, 2'b11)
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      #1;
      `MNEF_CHK({derr_flag_q, fetch_data_q, fetch_valid_q, cdone_q}, 11'h000)
      $display("test_reset done");
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      end_of_test();
   end

   initial begin
      n_errors = 0;
      n_checks = 0;
      rst = 1'b1;
      dreq = '0;
      dinject = 13'h0000;
      fetch_en = 1'b0;
      fetch_addr = 15'h0000;
      creq = '0;
      derr_clear = 1'b0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      test_dram();
      test_fetch();
      test_ctrl();
      test_erase();
      test_reset();
      end_of_test();
   end
endmodule

bind mnef_top mnef_top_checker i_chk (.clk, .rst, .dreq, .drdata_q, .drvalid_q, .dcorr_q, .fetch_en,
   .fetch_addr, .fetch_ready, .fetch_valid_q, .fetch_corr_q, .creq, .cready, .cdone_q, .crefused_q,
   .areq, .derr_clear, .derr_flag_q);
